// ### core/sxa_exec.sv
// Execute slice: accumulator, status flags and file-register write port
`timescale 1ns/1ns
`default_nettype none
module sxa_exec (
    input  wire logic                    sys_clk,
    input  wire logic                    nrst,
    input  wire logic                    op_valid,
    input  wire sxa_pkg::sxa_op_e        op,
    input  wire logic [7:0]              imm,
    input  wire logic [6:0]              reg_addr,
    input  wire logic                    dest,
    input  wire logic [7:0]              reg_rd,
    output logic [7:0]                   acc,
    output logic                         carry_flag,
    output logic                         digit_carry_flag,
    output logic                         zero_flag,
    output logic                         reg_we,
    output logic [6:0]                   reg_wa,
    output logic [7:0]                   reg_wd,
    output logic                         done
);
    import sxa_pkg::*;

    sxa_res_if res ();

    sxa_calc u_calc (
        .op     (op),
        .acc    (acc),
        .imm    (imm),
        .reg_rd (reg_rd),
        .dest   (dest),
        .res    (res.src)
    );

    // ====================================================================
    // Accumulator: reg_rd must be valid in the same cycle as op_valid
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            acc <= ACC_RST;
        end else if (op_valid && op != SXA_NOP && !res.to_reg) begin
            acc <= res.result;
        end
    end

    // ====================================================================
    // Status flags
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            carry_flag       <= FLAG_RST;
            digit_carry_flag <= FLAG_RST;
        end else if (op_valid && res.upd_cdc) begin
            carry_flag       <= res.carry;
            digit_carry_flag <= res.digit_carry_flag;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            zero_flag <= FLAG_RST;
        end else if (op_valid && res.upd_zero) begin
            zero_flag <= (res.result == 8'h00);
        end
    end

    // ====================================================================
    // File-register write port, one-cycle strobe
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reg_we <= 1'b0;
            reg_wa <= 7'h00;
            reg_wd <= 8'h00;
        end else begin
            reg_we <= op_valid && res.to_reg;
            if (op_valid && res.to_reg) begin
                reg_wa <= reg_addr;
                reg_wd <= res.result;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            done <= 1'b0;
        end else begin
            done <= op_valid && op != SXA_NOP;
        end
    end

    // ====================================================================
    // Checks
    // Operands only stand in the issue cycle, so the operand checks lean on $past; the zero, idle and hold checks need none
    sequence s_issue_sub;
        op_valid && (op == SXA_SUB_ACC_FROM_IMM || op == SXA_SUB_ACC_FROM_REG);
    endsequence

    sequence s_issue_imm;
        op_valid && (op == SXA_SUB_ACC_FROM_IMM || op == SXA_XOR_IMM_INTO_ACC);
    endsequence

    sequence s_issue_reg_wb;
        op_valid && dest && (op == SXA_SUB_ACC_FROM_REG || op == SXA_XOR_ACC_WITH_REG
            || op == SXA_SWAP_REG_NIBBLES);
    endsequence

    property p_sub_imm;
        @(posedge sys_clk) disable iff (!nrst)
        op_valid && op == SXA_SUB_ACC_FROM_IMM |=> acc == 8'($past(imm) - $past(acc));
    endproperty
    a_sub_imm: assert property (p_sub_imm) else $error("imm minus acc wrong");

    property p_xor_imm;
        @(posedge sys_clk) disable iff (!nrst)
        op_valid && op == SXA_XOR_IMM_INTO_ACC |=> acc == ($past(imm) ^ $past(acc))
            && $stable(carry_flag) && $stable(digit_carry_flag);
    endproperty
    a_xor_imm: assert property (p_xor_imm) else $error("xor imm wrong");

    property p_sub_carry;
        @(posedge sys_clk) disable iff (!nrst)
        s_issue_sub |=> carry_flag == (($past(op) == SXA_SUB_ACC_FROM_IMM ? $past(imm)
            : $past(reg_rd)) >= $past(acc));
    endproperty
    a_sub_carry: assert property (p_sub_carry) else $error("borrow flag wrong");

    property p_dest_reg;
        @(posedge sys_clk) disable iff (!nrst)
        s_issue_reg_wb |=> reg_we && reg_wa == $past(reg_addr) && $stable(acc);
    endproperty
    a_dest_reg: assert property (p_dest_reg) else $error("dest reg not written");

    property p_xor_reg;
        @(posedge sys_clk) disable iff (!nrst)
        op_valid && !dest && op == SXA_XOR_ACC_WITH_REG |=> !reg_we
            && acc == ($past(reg_rd) ^ $past(acc)) && $stable(carry_flag);
    endproperty
    a_xor_reg: assert property (p_xor_reg) else $error("xor reg wrong");

    property p_swap;
        @(posedge sys_clk) disable iff (!nrst)
        op_valid && dest && op == SXA_SWAP_REG_NIBBLES |=>
            {reg_wd[3:0], reg_wd[7:4]} == $past(reg_rd) && $stable(zero_flag)
            && $stable(carry_flag) && $stable(digit_carry_flag);
    endproperty
    a_swap: assert property (p_swap) else $error("swap wrong");

    property p_zero;
        @(posedge sys_clk) disable iff (!nrst)
        op_valid && !dest && op == SXA_SUB_ACC_FROM_REG |=> zero_flag == (acc == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    property p_dc;
        @(posedge sys_clk) disable iff (!nrst)
        s_issue_sub ##1 1 |-> digit_carry_flag ==
            ((($past(op) == SXA_SUB_ACC_FROM_IMM ? $past(imm) : $past(reg_rd)) & 8'h0f)
            >= ($past(acc) & 8'h0f));
    endproperty
    a_dc: assert property (p_dc) else $error("digit carry wrong");

    // Destination select is ignored for immediates, a stray dest must not write
    property p_imm_no_write;
        @(posedge sys_clk) disable iff (!nrst)
        s_issue_imm |=> !reg_we && done;
    endproperty
    a_imm_no_write: assert property (p_imm_no_write) else $error("imm op wrote file");

    property p_xor_imm_zero;
        @(posedge sys_clk) disable iff (!nrst)
        op_valid && op == SXA_XOR_IMM_INTO_ACC |=> zero_flag == (acc == 8'h00);
    endproperty
    a_xor_imm_zero: assert property (p_xor_imm_zero) else $error("xor imm zero wrong");

    property p_sub_imm_zero;
        @(posedge sys_clk) disable iff (!nrst)
        op_valid && op == SXA_SUB_ACC_FROM_IMM |=> zero_flag == (acc == 8'h00);
    endproperty
    a_sub_imm_zero: assert property (p_sub_imm_zero) else $error("sub imm zero wrong");

    property p_sub_reg_acc;
        @(posedge sys_clk) disable iff (!nrst)
        op_valid && !dest && op == SXA_SUB_ACC_FROM_REG |=> !reg_we
            && acc == 8'($past(reg_rd) - $past(acc));
    endproperty
    a_sub_reg_acc: assert property (p_sub_reg_acc) else $error("sub reg to acc wrong");

    property p_sub_reg_wb;
        @(posedge sys_clk) disable iff (!nrst)
        op_valid && dest && op == SXA_SUB_ACC_FROM_REG |=>
            reg_wd == 8'($past(reg_rd) - $past(acc)) && zero_flag == (reg_wd == 8'h00);
    endproperty
    a_sub_reg_wb: assert property (p_sub_reg_wb) else $error("sub reg write wrong");

    property p_xor_reg_wb;
        @(posedge sys_clk) disable iff (!nrst)
        op_valid && dest && op == SXA_XOR_ACC_WITH_REG |=>
            reg_wd == ($past(reg_rd) ^ $past(acc)) && zero_flag == (reg_wd == 8'h00)
            && $stable(carry_flag) && $stable(digit_carry_flag);
    endproperty
    a_xor_reg_wb: assert property (p_xor_reg_wb) else $error("xor reg write wrong");

    property p_swap_acc;
        @(posedge sys_clk) disable iff (!nrst)
        op_valid && !dest && op == SXA_SWAP_REG_NIBBLES |=> !reg_we
            && {acc[3:0], acc[7:4]} == $past(reg_rd) && $stable(zero_flag)
            && $stable(carry_flag) && $stable(digit_carry_flag);
    endproperty
    a_swap_acc: assert property (p_swap_acc) else $error("swap to acc wrong");

    // A refused issue must leave every architectural bit alone
    property p_idle;
        @(posedge sys_clk) disable iff (!nrst)
        !op_valid || op == SXA_NOP |=> !reg_we && !done && $stable(acc)
            && $stable(carry_flag) && $stable(digit_carry_flag) && $stable(zero_flag);
    endproperty
    a_idle: assert property (p_idle) else $error("refused issue changed state");

    // Write address and data hold between writes for the file side
    property p_wb_hold;
        @(posedge sys_clk) disable iff (!nrst)
        !op_valid |=> $stable(reg_wa) && $stable(reg_wd);
    endproperty
    a_wb_hold: assert property (p_wb_hold) else $error("write port moved");
endmodule // sxa_exec
`default_nettype wire

// ### core/sxa_pkg.sv
// Shared constants and types for the subtract/xor/swap execute slice
package sxa_pkg;
    localparam int DATA_W   = 8;
    localparam int ADDR_W   = 7;
    localparam int NIB_LO   = 0;
    localparam int NIB_HI   = 4;
    localparam int NIB_W    = 4;
    localparam logic [7:0] ACC_RST    = 8'h00;
    localparam logic       FLAG_RST   = 1'b0;
    localparam logic       DEST_ACC   = 1'b0;
    localparam logic       DEST_REG   = 1'b1;
    localparam int OP_W     = 3;

    typedef enum logic [2:0] {
        SXA_NOP,
        SXA_SUB_ACC_FROM_IMM,
        SXA_XOR_IMM_INTO_ACC,
        SXA_SUB_ACC_FROM_REG,
        SXA_XOR_ACC_WITH_REG,
        SXA_SWAP_REG_NIBBLES
    } sxa_op_e;
endpackage

// ### core/sxa_res_if.sv
// Result bundle passed from the combinational unit to the execute stage
`timescale 1ns/1ns
`default_nettype none
interface sxa_res_if;
    logic [7:0] result;
    logic       carry;
    logic       digit_carry_flag;
    logic       upd_cdc;
    logic       upd_zero;
    logic       to_reg;
    modport src (output result, carry, digit_carry_flag, upd_cdc, upd_zero, to_reg);
    modport dst (input  result, carry, digit_carry_flag, upd_cdc, upd_zero, to_reg);
endinterface
`default_nettype wire

// ### core/sxa_calc.sv
// Combinational result and flag computation for the five operations
`timescale 1ns/1ns
`default_nettype none
module sxa_calc (
    input  wire sxa_pkg::sxa_op_e op,
    input  wire logic [7:0]       acc,
    input  wire logic [7:0]       imm,
    input  wire logic [7:0]       reg_rd,
    input  wire logic             dest,
    sxa_res_if.src                res
);
    import sxa_pkg::*;
    logic [8:0] diff;
    logic [4:0] ldiff;
    logic [7:0] minu;

    // ====================================================================
    // Operand select and two's complement subtract
    always_comb begin
        minu  = (op == SXA_SUB_ACC_FROM_IMM) ? imm : reg_rd;
        // Add of the inverted subtrahend plus one: carry out means no borrow
        diff  = {1'b0, minu} + {1'b0, ~acc} + 9'h001;
        ldiff = {1'b0, minu[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
    end

    always_comb begin
        res.result           = 8'h00;
        res.carry            = diff[8];
        res.digit_carry_flag = ldiff[4];
        res.upd_cdc          = 1'b0;
        res.upd_zero         = 1'b0;
        res.to_reg           = 1'b0;
        case (op)
            SXA_SUB_ACC_FROM_IMM: begin
                res.result   = diff[7:0];
                res.upd_cdc  = 1'b1;
                res.upd_zero = 1'b1;
            end
            SXA_XOR_IMM_INTO_ACC: begin
                res.result   = acc ^ imm;
                res.upd_zero = 1'b1;
            end
            SXA_SUB_ACC_FROM_REG: begin
                res.result   = diff[7:0];
                res.upd_cdc  = 1'b1;
                res.upd_zero = 1'b1;
                res.to_reg   = (dest == DEST_REG);
            end
            SXA_XOR_ACC_WITH_REG: begin
                res.result   = acc ^ reg_rd;
                res.upd_zero = 1'b1;
                res.to_reg   = (dest == DEST_REG);
            end
            SXA_SWAP_REG_NIBBLES: begin
                res.result = {reg_rd[NIB_LO +: NIB_W], reg_rd[NIB_HI +: NIB_W]};
                res.to_reg = (dest == DEST_REG);
            end
            default: begin
                res.result = 8'h00;
            end
        endcase
    end
endmodule // sxa_calc
`default_nettype wire

// ### sim/sxa_exec_tb.sv
// Self-checking bench for the subtract/xor/swap execute slice
`timescale 1ns/1ns
`default_nettype none
module sxa_exec_tb;
    import sxa_pkg::*;
    // =====================================================
    // Stimulus and observed signals
    logic       sys_clk  = 1'b0;
    logic       nrst     = 1'b0;
    logic       op_valid = 1'b0;
    sxa_op_e    op       = SXA_NOP;
    logic [7:0] imm      = 8'h00;
    logic [6:0] reg_addr = 7'h00;
    logic       dest     = 1'b0;
    logic [7:0] reg_rd   = 8'h00;
    logic [7:0] acc, reg_wd, e_acc;
    logic [6:0] reg_wa;
    logic       carry_flag, digit_carry_flag, zero_flag, reg_we, done;
    logic       e_c, e_dc, e_z;
    int         fails      = 0;
    int         n_compared = 0;

    sxa_exec i_dut (.sys_clk(sys_clk), .nrst(nrst), .op_valid(op_valid), .op(op), .imm(imm),
        .reg_addr(reg_addr), .dest(dest), .reg_rd(reg_rd), .acc(acc), .carry_flag(carry_flag),
        .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag), .reg_we(reg_we),
        .reg_wa(reg_wa), .reg_wd(reg_wd), .done(done));

    always #5 sys_clk = ~sys_clk;

    // =====================================================
    // Shared helpers
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Reference model runs ahead of the issue, so expectations never come from outputs
    task automatic run_op(input logic v, input sxa_op_e o, input logic [7:0] k,
                          input logic [6:0] a, input logic d, input logic [7:0] rd);
        logic [7:0] src;
        logic [7:0] res;
        logic       live;
        logic       to_reg;
        live   = v && (o != SXA_NOP);
        src    = (o == SXA_SUB_ACC_FROM_IMM || o == SXA_XOR_IMM_INTO_ACC) ? k : rd;
        to_reg = live && d && (o inside {SXA_SUB_ACC_FROM_REG, SXA_XOR_ACC_WITH_REG,
                                         SXA_SWAP_REG_NIBBLES});
        res    = e_acc;
        if (live) begin
            case (o)
                SXA_SUB_ACC_FROM_IMM, SXA_SUB_ACC_FROM_REG: begin
                    res  = src - e_acc;
                    e_c  = src >= e_acc;
                    e_dc = src[3:0] >= e_acc[3:0];
                    e_z  = res == 8'h00;
                end
                SXA_XOR_IMM_INTO_ACC, SXA_XOR_ACC_WITH_REG: begin
                    res = src ^ e_acc;
                    e_z = res == 8'h00;
                end
                default: res = {src[3:0], src[7:4]};
            endcase
            if (!to_reg) e_acc = res;
        end
        @(posedge sys_clk);
        op_valid <= v;
        op       <= o;
        imm      <= k;
        reg_addr <= a;
        dest     <= d;
        reg_rd   <= rd;
        @(posedge sys_clk);
        op_valid <= 1'b0;
        reg_rd   <= ~rd;
        #1;
        chk("acc", e_acc, acc);
        chk("carry_flag", {7'h00, e_c}, {7'h00, carry_flag});
        chk("digit_carry_flag", {7'h00, e_dc}, {7'h00, digit_carry_flag});
        chk("zero_flag", {7'h00, e_z}, {7'h00, zero_flag});
        chk("reg_we", {7'h00, to_reg}, {7'h00, reg_we});
        chk("done", {7'h00, live}, {7'h00, done});
        if (to_reg) begin
            chk("reg_wa", {1'b0, a}, {1'b0, reg_wa});
            chk("reg_wd", res, reg_wd);
        end
    endtask

    // Issues on consecutive edges: the second must see the accumulator the first wrote
    task automatic t_back_to_back();
        @(posedge sys_clk);
        op_valid <= 1'b1;
        op       <= SXA_XOR_IMM_INTO_ACC;
        imm      <= 8'h0f;
        dest     <= 1'b1;
        @(posedge sys_clk);
        op       <= SXA_SUB_ACC_FROM_IMM;
        imm      <= 8'h20;
        e_acc = e_acc ^ 8'h0f;
        #1;
        chk("acc", e_acc, acc);
        chk("zero_flag", {7'h00, e_acc == 8'h00}, {7'h00, zero_flag});
        e_c   = 8'h20 >= e_acc;
        e_dc  = 4'h0 >= e_acc[3:0];
        e_acc = 8'h20 - e_acc;
        e_z   = e_acc == 8'h00;
        @(posedge sys_clk);
        op_valid <= 1'b0;
        #1;
        chk("acc", e_acc, acc);
        chk("carry_flag", {7'h00, e_c}, {7'h00, carry_flag});
        chk("digit_carry_flag", {7'h00, e_dc}, {7'h00, digit_carry_flag});
        chk("zero_flag", {7'h00, e_z}, {7'h00, zero_flag});
        chk("reg_we", 8'h00, {7'h00, reg_we});
        chk("done", 8'h01, {7'h00, done});
        @(posedge sys_clk);
        #1;
        chk("done", 8'h00, {7'h00, done});
        chk("acc", e_acc, acc);
    endtask

    // =====================================================
    // Scenarios
    // Used at start and again mid-run, when the outputs hold nonzero values
    task automatic t_reset();
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        #1;
        chk("acc", ACC_RST, acc);
        chk("flags", 8'h00, {5'h00, carry_flag, digit_carry_flag, zero_flag});
        chk("strobes", 8'h00, {6'h00, reg_we, done});
        chk("reg_wa", 8'h00, {1'b0, reg_wa});
        chk("reg_wd", 8'h00, reg_wd);
        {e_acc, e_c, e_dc, e_z} = {ACC_RST, FLAG_RST, FLAG_RST, FLAG_RST};
    endtask

    // Equal, no-borrow, low-nibble borrow, top of range and full borrow
    task automatic t_sub_imm();
        logic [7:0] ks [5] = '{8'h00, 8'h35, 8'h24, 8'hff, 8'h00};
        foreach (ks[i]) run_op(1'b1, SXA_SUB_ACC_FROM_IMM, ks[i], 7'h00, 1'b1, 8'h00);
    endtask

    task automatic t_xor_imm();
        run_op(1'b1, SXA_XOR_IMM_INTO_ACC, 8'h5a, 7'h00, 1'b0, 8'h00);
        run_op(1'b1, SXA_XOR_IMM_INTO_ACC, e_acc, 7'h00, 1'b0, 8'h00);
    endtask

    task automatic t_sub_reg();
        run_op(1'b1, SXA_SUB_ACC_FROM_REG, 8'h00, 7'h7f, 1'b1, 8'h81);
        run_op(1'b1, SXA_SUB_ACC_FROM_REG, 8'h00, 7'h00, 1'b0, 8'h08);
        run_op(1'b1, SXA_SUB_ACC_FROM_REG, 8'h00, 7'h2c, 1'b1, e_acc);
    endtask

    task automatic t_xor_reg();
        run_op(1'b1, SXA_XOR_ACC_WITH_REG, 8'h00, 7'h7f, 1'b1, 8'hc3);
        run_op(1'b1, SXA_XOR_ACC_WITH_REG, 8'h00, 7'h11, 1'b0, e_acc);
    endtask

    // Zero is set going in, so a nonzero swap result must leave it alone
    task automatic t_swap();
        run_op(1'b1, SXA_SWAP_REG_NIBBLES, 8'h00, 7'h40, 1'b0, 8'ha5);
        run_op(1'b1, SXA_SWAP_REG_NIBBLES, 8'h00, 7'h7f, 1'b1, 8'h1e);
    endtask

    task automatic t_refused();
        run_op(1'b0, SXA_SUB_ACC_FROM_IMM, 8'h77, 7'h01, 1'b0, 8'h00);
        run_op(1'b1, SXA_NOP, 8'h77, 7'h01, 1'b1, 8'h33);
    endtask

    // =====================================================
    // Verdict and run control
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        t_reset();
        t_sub_imm();
        t_xor_imm();
        t_sub_reg();
        t_xor_reg();
        t_swap();
        t_refused();
        t_reset();
        t_back_to_back();
        finish_test();
    end

    // Whole run is well under a thousand cycles
    initial begin
        #20000;
        fails++;
        finish_test();
    end
endmodule // sxa_exec_tb
`default_nettype wire
